// ===== hdl/drs_pkg.sv
// package: constants and types for the ddr3 refresh and self-refresh block
package drs_pkg;
  localparam int ROW_W        = 16;     // internal refresh row counter width
  localparam int BANKS        = 8;      // bank count
  localparam int T_RFC_CYC    = 7;      // refresh cycle time in clocks
  localparam int T_REFI_CYC   = 156;    // refresh interval in clocks
  localparam int T_CKE_CYC    = 3;      // least self-refresh residence
  localparam int T_XS_CYC     = 8;      // exit to non-dll command
  localparam int T_XSDLL_CYC  = 512;    // exit to dll command
  localparam int T_WR_SRX_CYC = 512;    // exit to first write
  localparam int MAX_DEFER    = 8;      // deferral / pull-in budget
  localparam int CRED_W       = 5;      // signed credit width
  localparam logic [ROW_W-1:0] ROW_RST = 16'h0000;
  typedef enum logic [2:0] {
    DRS_IDLE, DRS_REF, DRS_SR, DRS_SR_REF, DRS_XS, DRS_XSDLL
  } drs_state_t;
endpackage

// ===== hdl/drs_timer.sv
// file: reusable down-counting cycle timer
`timescale 1ns/1ps
module drs_timer #(
  parameter int W = 10
) (
  input  wire logic         clk,   // clock
  input  wire logic         rst_n, // async reset, active low
  input  wire logic         load,  // start count
  input  wire logic [W-1:0] value, // cycles to count
  output logic              busy   // count running
);
  logic [W-1:0] cnt;
  // counts down to zero; busy holds until zero reached
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= value;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end
  assign busy = (cnt != '0);
endmodule // drs_timer

// ===== hdl/drs_refresh.sv
// file: ddr3 refresh decode and self-refresh sequencing, device side
// Notes on behaviour
// - cs, ras, cas low with we high and cke high means refresh
// - refresh rows come from internal counter, address bus ignored
// - finished refresh leaves all banks precharged idle
// - refresh command with cke low means self-refresh entry
// - dll off on entry, re-enabled with reset on exit
// - in self-refresh only cke, reset and a nop on the command pins are heeded
// - device launches an internal refresh within tcke of entry
`timescale 1ns/1ps
module drs_refresh #(
  parameter int TRFC   = drs_pkg::T_RFC_CYC,    // refresh cycle clocks
  parameter int TREFI  = drs_pkg::T_REFI_CYC,   // refresh interval clocks
  parameter int TCKE   = drs_pkg::T_CKE_CYC,    // self-refresh residence
  parameter int TXS    = drs_pkg::T_XS_CYC,     // exit to non-dll command
  parameter int TXSDLL = drs_pkg::T_XSDLL_CYC   // exit to dll command
) (
  input  wire logic                          MCLK,        // controller clock
  input  wire logic                          RST_N,       // async reset, active low
  input  wire logic                          CS_N,        // chip select pin
  input  wire logic                          RAS_N,       // row strobe pin
  input  wire logic                          CAS_N,       // column strobe pin
  input  wire logic                          WE_N,        // write enable pin
  input  wire logic                          CKE,         // clock enable pin
  input  wire logic                          ODT,         // termination pin
  output logic                               REF_BUSY,    // internal refresh running
  output logic [drs_pkg::ROW_W-1:0]          REF_ROW,     // internal row being refreshed
  output logic                               BANKS_IDLE,  // all banks precharged idle
  output logic                               IN_SR,       // in self-refresh
  output logic                               DLL_ON,      // dll enabled
  output logic                               DLL_RESET,   // dll reset pulse on exit
  output logic                               DLL_LOCKED,  // txsdll elapsed since exit
  output logic                               XS_DONE,     // txs elapsed since exit
  output logic                               WRITE_OK,    // writes allowed again
  output logic                               ODT_ACTIVE,  // termination enabled
  output logic signed [drs_pkg::CRED_W-1:0]  CREDIT,      // refresh credit, neg = owed
  output logic                               ERR_TIMING   // sticky controller violation
);
  import drs_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: two flops before any logic reads a pin
  logic [5:0] s1, s2;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      s1 <= 6'h1f;
      s2 <= 6'h1f;
    end else begin
      s1 <= {ODT, CKE, WE_N, CAS_N, RAS_N, CS_N};
      s2 <= s1;
    end
  end
  // synchronised pin levels; reset values match the idle bus, so no false command
  wire cs_n = s2[0];
  wire ras_n = s2[1];
  wire cas_n = s2[2];
  wire we_n = s2[3];
  wire cke = s2[4];
  wire odt = s2[5];
  // previous cke, reset high so that release of reset never looks like an exit
  logic cke_d;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) cke_d <= 1'b1;
    else        cke_d <= cke;
  end

  //////////////////////////////////////////////////////////////////////////
  // command decode
  wire ref_pat = !cs_n && !ras_n && !cas_n && we_n;
  wire is_ref  = ref_pat && cke && cke_d;
  wire is_sre  = ref_pat && !cke && cke_d;
  wire is_nop  = cs_n || (ras_n && cas_n && we_n);
  wire is_srx  = cke && !cke_d && is_nop;

  //////////////////////////////////////////////////////////////////////////
  // state and timers
  drs_state_t state, next_state;
  logic rfc_busy, cke_busy, xs_busy, xsdll_busy, refi_busy;
  logic ld_rfc, ld_cke, ld_xs, ld_xsdll;
  logic ref_since_exit;

  drs_timer #(.W(10)) u_rfc (.clk(MCLK), .rst_n(RST_N), .load(ld_rfc),
    .value(10'(TRFC)), .busy(rfc_busy));
  drs_timer #(.W(10)) u_cke (.clk(MCLK), .rst_n(RST_N), .load(ld_cke),
    .value(10'(TCKE)), .busy(cke_busy));
  drs_timer #(.W(10)) u_xs (.clk(MCLK), .rst_n(RST_N), .load(ld_xs),
    .value(10'(TXS)), .busy(xs_busy));
  drs_timer #(.W(10)) u_xsdll (.clk(MCLK), .rst_n(RST_N), .load(ld_xsdll),
    .value(10'(TXSDLL)), .busy(xsdll_busy));
  // interval timer reloads itself on expiry; loading trefi-1 gives a trefi period
  wire ld_refi = !refi_busy;
  drs_timer #(.W(10)) u_refi (.clk(MCLK), .rst_n(RST_N), .load(ld_refi),
    .value(10'(TREFI - 1)), .busy(refi_busy));

  // self-refresh internal refresh launched on entry, inside tcke
  // entry only from states that decode it; exit is also taken while the entry refresh runs
  assign ld_cke   = (state == DRS_IDLE || state == DRS_XSDLL) && is_sre;
  assign ld_rfc   = ((state == DRS_IDLE || state == DRS_XSDLL) && is_ref) || ld_cke;
  assign ld_xs    = (state == DRS_SR || state == DRS_SR_REF) && is_srx && !cke_busy;
  assign ld_xsdll = ld_xs;

  // next-state: in self-refresh only cke and a nop on the command pins are decoded
  always_comb begin
    next_state = state;
    case (state)
      DRS_IDLE:   if (is_sre) next_state = DRS_SR_REF;
                  else if (is_ref) next_state = DRS_REF;
      DRS_REF:    if (!rfc_busy) next_state = DRS_IDLE;
      DRS_SR_REF: begin
        if (ld_xs) next_state = DRS_XS;
        else if (!rfc_busy) next_state = DRS_SR;
      end
      DRS_SR:     if (ld_xs) next_state = DRS_XS;
      DRS_XS:     if (!xs_busy) next_state = DRS_XSDLL;
      DRS_XSDLL: begin
        if (is_sre) next_state = DRS_SR_REF;
        else if (is_ref) next_state = DRS_REF;
        else if (!xsdll_busy) next_state = DRS_IDLE;
      end
      default:    next_state = DRS_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) state <= DRS_IDLE;
    else        state <= next_state;
  end

  //////////////////////////////////////////////////////////////////////////
  // internal row counter, advanced per refresh; address bus never read
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N)      REF_ROW <= ROW_RST;
    else if (ld_rfc) REF_ROW <= REF_ROW + 1'b1;
  end

  // refresh credit: interval tick owes one outside self-refresh, refresh pays one, clamped at MAX_DEFER above only
  wire tick = !refi_busy;
  // the refresh launched by self-refresh entry is internal and earns no credit
  wire ext_ref = ld_rfc && !ld_cke;
  logic signed [CRED_W-1:0] next_credit;
  always_comb begin
    next_credit = CREDIT;
    if (ext_ref && !tick && CREDIT < CRED_W'(MAX_DEFER)) next_credit = CREDIT + 1'b1;
    else if (tick && !ext_ref && (state != DRS_SR && state != DRS_SR_REF))
      next_credit = CREDIT - 1'b1;
  end
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) CREDIT <= '0;
    else        CREDIT <= next_credit;
  end

  // re-entry after exit needs one refresh first; checked only for entry from DRS_XSDLL
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N)     ref_since_exit <= 1'b1;
    else if (ld_xs) ref_since_exit <= 1'b0;
    else if (is_ref && state == DRS_XSDLL) ref_since_exit <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // controller violation monitor: sticky, for debug only
  wire v_rfc  = (state == DRS_REF) && !is_nop;
  wire v_defr = (CREDIT < -CRED_W'(MAX_DEFER));
  wire v_sre  = is_sre && ((CREDIT < 0) || rfc_busy || odt
                || (state == DRS_XSDLL && (xs_busy || !ref_since_exit)));
  wire v_cke  = (state == DRS_SR || state == DRS_SR_REF) && cke && cke_busy;
  wire v_xs   = (state == DRS_XS) && !is_nop;
  wire v_exit = (state == DRS_XSDLL) && (!cke || odt) && !is_sre;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) ERR_TIMING <= 1'b0;
    else if (v_rfc || v_defr || v_sre || v_cke || v_xs || v_exit) ERR_TIMING <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // registered status and dll control
  // write lockout counts a fixed 512 clocks, independent of the txsdll setting
  logic [9:0] wr_cnt;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) wr_cnt <= '0;
    else if (ld_xs) wr_cnt <= 10'(T_WR_SRX_CYC);
    else if (wr_cnt != '0) wr_cnt <= wr_cnt - 1'b1;
  end
  wire in_sr = (state == DRS_SR) || (state == DRS_SR_REF);
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      REF_BUSY   <= 1'b0;
      BANKS_IDLE <= 1'b1;
      IN_SR      <= 1'b0;
      DLL_ON     <= 1'b1;
      DLL_RESET  <= 1'b0;
      DLL_LOCKED <= 1'b1;
      XS_DONE    <= 1'b1;
      WRITE_OK   <= 1'b1;
      ODT_ACTIVE <= 1'b0;
    end else begin
      REF_BUSY   <= rfc_busy || ld_rfc;
      BANKS_IDLE <= !(rfc_busy || ld_rfc);
      IN_SR      <= in_sr || ld_cke;
      DLL_ON     <= !(in_sr || ld_cke);
      DLL_RESET  <= ld_xs;
      DLL_LOCKED <= !(xsdll_busy || ld_xsdll || in_sr || ld_cke);
      XS_DONE    <= !(xs_busy || ld_xs || in_sr || ld_cke);
      WRITE_OK   <= (wr_cnt == '0) && !ld_xs && !in_sr && !ld_cke;
      ODT_ACTIVE <= odt && !in_sr && !ld_cke && !xsdll_busy;
    end
  end
endmodule // drs_refresh

// ===== dv/drs_checker.sv
// checker: port relations of the refresh and self-refresh block
`timescale 1ns/1ps
module drs_checker #(
  parameter int TRFC = 7                                   // refresh cycle clocks
) (
  input wire logic                          MCLK,        // clock
  input wire logic                          RST_N,       // async reset, active low
  input wire logic                          CS_N,        // chip select pin
  input wire logic                          RAS_N,       // row strobe pin
  input wire logic                          CAS_N,       // column strobe pin
  input wire logic                          WE_N,        // write enable pin
  input wire logic                          CKE,         // clock enable pin
  input wire logic                          ODT,         // termination pin
  input wire logic                          REF_BUSY,    // internal refresh running
  input wire logic [drs_pkg::ROW_W-1:0]     REF_ROW,     // internal row
  input wire logic                          BANKS_IDLE,  // all banks idle
  input wire logic                          IN_SR,       // in self-refresh
  input wire logic                          DLL_ON,      // dll enabled
  input wire logic                          DLL_RESET,   // dll reset pulse
  input wire logic                          DLL_LOCKED,  // txsdll elapsed
  input wire logic                          XS_DONE,     // txs elapsed
  input wire logic                          WRITE_OK,    // writes allowed
  input wire logic                          ODT_ACTIVE,  // termination enabled
  input wire logic signed [drs_pkg::CRED_W-1:0] CREDIT,  // refresh credit
  input wire logic                          ERR_TIMING   // sticky violation
);
  localparam int RFC_LO = TRFC;
  localparam int RFC_HI = TRFC + 1;
  wire ref_cmd = !CS_N && !RAS_N && !CAS_N && WE_N;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  //////////////////////////////////////////////////////////////////////
  // a busy engine masks a new request, so only idle launches are checked
  chk_ref_launch: assert property (
    ref_cmd && CKE && $past(CKE) && !IN_SR && !REF_BUSY |-> ##[1:4] REF_BUSY) else $error("no launch");
  chk_row_step: assert property (
    $rose(REF_BUSY) |-> REF_ROW == $past(REF_ROW) + 16'h0001) else $error("row not stepped");
  chk_busy_len: assert property (
    $rose(REF_BUSY) |-> ##[RFC_LO:RFC_HI] $fell(REF_BUSY)) else $error("busy length");
  chk_idle_mirror: assert property (BANKS_IDLE == !REF_BUSY) else $error("banks idle");
  chk_sr_dll: assert property (IN_SR |-> !DLL_ON) else $error("dll on in sr");
  chk_odt_off: assert property (
    IN_SR || !DLL_LOCKED |-> !ODT_ACTIVE) else $error("termination on");
  chk_sr_refresh: assert property ($rose(IN_SR) |-> ##[0:3] REF_BUSY) else $error("no sr refresh");
  chk_sr_hold: assert property (
    IN_SR && !CKE && !$past(CKE) && !$past(CKE, 2) |=> IN_SR) else $error("left sr");
  // the reset pulse is launched with the exit decode, one cycle ahead of in_sr falling
  chk_exit_pulse: assert property (
    $fell(IN_SR) |-> $past(DLL_RESET) && !DLL_RESET && DLL_ON) else $error("dll reset pulse");
  chk_exit_wait: assert property (
    $fell(IN_SR) |-> ##1 (!XS_DONE && !DLL_LOCKED && !WRITE_OK) [*5]) else $error("exit waits");
  chk_err_sticky: assert property (ERR_TIMING |=> ERR_TIMING) else $error("error cleared");
  chk_credit_cap: assert property (CREDIT <= 8) else $error("credit above cap");
  // pin to termination status is two sync flops plus the status register
  chk_odt_follow: assert property (!ODT |-> ##3 !ODT_ACTIVE) else $error("termination stuck on");
  cov_entry: cover property ($rose(IN_SR));
  cov_credit_full: cover property (CREDIT == 8);
  cov_exit: cover property ($fell(IN_SR));
  cov_err: cover property ($rose(ERR_TIMING));
endmodule // drs_checker
bind drs_refresh drs_checker #(.TRFC(TRFC)) u_drs_checker (
  .MCLK       (MCLK),
  .RST_N      (RST_N),
  .CS_N       (CS_N),
  .RAS_N      (RAS_N),
  .CAS_N      (CAS_N),
  .WE_N       (WE_N),
  .CKE        (CKE),
  .ODT        (ODT),
  .REF_BUSY   (REF_BUSY),
  .REF_ROW    (REF_ROW),
  .BANKS_IDLE (BANKS_IDLE),
  .IN_SR      (IN_SR),
  .DLL_ON     (DLL_ON),
  .DLL_RESET  (DLL_RESET),
  .DLL_LOCKED (DLL_LOCKED),
  .XS_DONE    (XS_DONE),
  .WRITE_OK   (WRITE_OK),
  .ODT_ACTIVE (ODT_ACTIVE),
  .CREDIT     (CREDIT),
  .ERR_TIMING (ERR_TIMING)
);

// ===== dv/drs_ctrl_model.sv
// model: memory controller driving command pins and clock enable
`timescale 1ns/1ps
module drs_ctrl_model (
  input  wire logic        MCLK,    // clock
  input  wire logic [1:0]  op,      // 0 nop, 1 refresh, 2 entry, 3 stay in sr
  input  wire logic        odt_req, // termination wanted
  input  wire logic [31:0] rnd,     // junk for unused lines
  output logic             CS_N,    // chip select
  output logic             RAS_N,   // row strobe
  output logic             CAS_N,   // column strobe
  output logic             WE_N,    // write enable
  output logic             CKE,     // clock enable
  output logic             ODT      // termination
);
  initial {CS_N, RAS_N, CAS_N, WE_N, CKE, ODT} = 6'h3e;
  // pins move at the falling edge; unused lines carry junk, never a held value
  always @(negedge MCLK) begin
    case (op)
      2'd0: {CS_N, RAS_N, CAS_N, WE_N, CKE} <= {1'b1, rnd[2:0], 1'b1};
      2'd1: {CS_N, RAS_N, CAS_N, WE_N, CKE} <= 5'h03;
      2'd2: {CS_N, RAS_N, CAS_N, WE_N, CKE} <= 5'h02;
      default: {CS_N, RAS_N, CAS_N, WE_N, CKE} <= {rnd[3:0], 1'b0};
    endcase
    ODT <= odt_req && op == 2'd0;
  end
endmodule // drs_ctrl_model

// ===== dv/test_drs_refresh.sv
// testbench: refresh rows, credit budget, self-refresh entry and exit
`timescale 1ns/1ps
module test_drs_refresh;
  import drs_pkg::*;
  logic MCLK = 1'b0, RST_N = 1'b0, odt_req = 1'b0, busy_q = 1'b0;
  logic [1:0] op = 2'd0;
  logic [31:0] rnd = 32'h4ec341fe;
  logic CS_N, RAS_N, CAS_N, WE_N, CKE, ODT, REF_BUSY, BANKS_IDLE, IN_SR, DLL_ON, DLL_RESET;
  logic DLL_LOCKED, XS_DONE, WRITE_OK, ODT_ACTIVE, ERR_TIMING;
  logic [ROW_W-1:0] REF_ROW, row_q[$];
  logic signed [CRED_W-1:0] CREDIT;
  int n_errors = 0, cmp_count = 0, cycles = 0, n = 0;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always #25 MCLK = ~MCLK;
  always @(negedge MCLK) rnd <= lfsr(rnd);
  drs_ctrl_model u_drs_ctrl_model (
    .MCLK    (MCLK),
    .op      (op),
    .odt_req (odt_req),
    .rnd     (rnd),
    .CS_N    (CS_N),
    .RAS_N   (RAS_N),
    .CAS_N   (CAS_N),
    .WE_N    (WE_N),
    .CKE     (CKE),
    .ODT     (ODT)
  );
  drs_refresh #(.TREFI(200), .TXSDLL(20)) u_drs_refresh (
    .MCLK       (MCLK),
    .RST_N      (RST_N),
    .CS_N       (CS_N),
    .RAS_N      (RAS_N),
    .CAS_N      (CAS_N),
    .WE_N       (WE_N),
    .CKE        (CKE),
    .ODT        (ODT),
    .REF_BUSY   (REF_BUSY),
    .REF_ROW    (REF_ROW),
    .BANKS_IDLE (BANKS_IDLE),
    .IN_SR      (IN_SR),
    .DLL_ON     (DLL_ON),
    .DLL_RESET  (DLL_RESET),
    .DLL_LOCKED (DLL_LOCKED),
    .XS_DONE    (XS_DONE),
    .WRITE_OK   (WRITE_OK),
    .ODT_ACTIVE (ODT_ACTIVE),
    .CREDIT     (CREDIT),
    .ERR_TIMING (ERR_TIMING)
  );
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic wait_val(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge MCLK);
      n++;
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watcher: each new launch takes the oldest expected row off the queue
  always @(negedge MCLK) begin
    busy_q <= REF_BUSY;
    if (REF_BUSY === 1'b1 && busy_q === 1'b0 && row_q.size() > 0) check(REF_ROW === row_q.pop_front(), "row");
  end
  // hang guard, far beyond the few thousand cycles the sequence needs
  always @(posedge MCLK) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      print_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge MCLK);
    RST_N = 1'b1;
    // requests change by non-blocking assignment so the model reads them one edge later, never in a race
    odt_req <= 1'b1;
    repeat (6) @(negedge MCLK);
    check(ODT_ACTIVE === 1'b1, "termination off");
    odt_req <= 1'b0;
    repeat (6) @(negedge MCLK);
    // ten early refreshes inside one interval; only nine earn credit, paying the first tick and then filling to eight
    for (int i = 1; i <= 10; i++) begin
      row_q.push_back(ROW_W'(i));
      op <= 2'd1;
      @(negedge MCLK);
      op <= 2'd0;
      repeat (T_RFC_CYC + 5) @(negedge MCLK);
    end
    check(row_q.size() == 0 && CREDIT === 5'sd8, "credit or rows");
    // entry with no debt, then junk pins while the clock enable stays low
    row_q.push_back(ROW_W'(11));
    op <= 2'd2;
    @(negedge MCLK);
    op <= 2'd3;
    wait_val(IN_SR, 1'b1, 6);
    check(IN_SR === 1'b1 && DLL_ON === 1'b0, "no entry");
    repeat (20) @(negedge MCLK);
    check(IN_SR === 1'b1 && REF_ROW === ROW_W'(11) && row_q.size() == 0, "sr lost");
    op <= 2'd0;
    wait_val(IN_SR, 1'b0, 6);
    @(negedge MCLK);
    check(IN_SR === 1'b0 && XS_DONE === 1'b0 && WRITE_OK === 1'b0, "exit");
    wait_val(DLL_LOCKED, 1'b1, 40);
    check(n >= 16 && n <= 24, "dll wait");
    wait_val(WRITE_OK, 1'b1, 600);
    check(n >= 480 && n <= 512, "write wait");
    // no refreshes: debt grows once per interval, a ninth owed one is flagged
    n = 0;
    while (CREDIT !== -5'sd8 && n < 4000) begin
      @(negedge MCLK);
      n++;
    end
    check(CREDIT === -5'sd8 && ERR_TIMING === 1'b0, "early error");
    wait_val(ERR_TIMING, 1'b1, 220);
    check(ERR_TIMING === 1'b1, "debt not flagged");
    print_verdict();
  end
endmodule // test_drs_refresh
